// ### core/frc_defs.svh
// Register map, field positions, reset values and timing constants for the fault relay.
// Assumes a 32-bit APB bus and a 50 MHz system clock.
`ifndef FRC_DEFS_SVH
`define FRC_DEFS_SVH

// Register byte offsets
`define FRC_OFF_CTRL      12'h000
`define FRC_OFF_PORTS     12'h004
`define FRC_OFF_RESET_T   12'h008
`define FRC_OFF_HOLD_T    12'h00C
`define FRC_OFF_ON_T      12'h010
`define FRC_OFF_OFF_T     12'h014
`define FRC_OFF_STATUS    12'h018
`define FRC_OFF_IRQ_STAT  12'h01C
`define FRC_OFF_IRQ_MASK  12'h020
`define FRC_OFF_CLEAR     12'h024

// Control field positions
`define FRC_CTRL_POWER_EN  0
`define FRC_CTRL_PSEL_LO   1
`define FRC_CTRL_PSEL_HI   2
`define FRC_CTRL_LINK_EN   3
`define FRC_CTRL_RING_EN   4
`define FRC_CTRL_PING_EN   5
`define FRC_CTRL_PRST_EN   6
`define FRC_CTRL_DRY_EN    7
`define FRC_CTRL_DI_EN     8
`define FRC_CTRL_DI_HIGH   9
`define FRC_CTRL_W         10

// Power source selection codes
`define FRC_PSEL_ONE       2'h1
`define FRC_PSEL_TWO       2'h2
`define FRC_PSEL_ANY       2'h3

// Cause bit positions (status bits 7:1 hold them shifted by one)
`define FRC_C_POWER        0
`define FRC_C_LINK         1
`define FRC_C_RING         2
`define FRC_C_PING         3
`define FRC_C_PRST         4
`define FRC_C_DRY          5
`define FRC_C_DI           6
`define FRC_NCAUSE         7
`define FRC_IRQ_RELAY      7
`define FRC_NIRQ           8

// Reset values and the seconds counter limit
`define FRC_CTRL_RST       10'h000
`define FRC_TIME_RST       16'h0000
`define FRC_SECS_MAX       16'hFFFF

// Timing: one second of a 20 ns clock
`define FRC_SEC_NS         1000000000
`define FRC_CLK_NS         20
`define FRC_TICK_CYCLES    (`FRC_SEC_NS / `FRC_CLK_NS)

`endif

// ### core/frc_pkg.sv
// Types shared by the fault relay design files.
// Assumes frc_defs.svh supplies the field widths.
`include "frc_defs.svh"

package frc_pkg;

	typedef enum logic [5:0] {
		FRC_ST_IDLE    = 6'h01,
		FRC_ST_RUN     = 6'h02,
		FRC_ST_OPEN    = 6'h04,
		FRC_ST_HOLD    = 6'h08,
		FRC_ST_DRY_ON  = 6'h10,
		FRC_ST_DRY_OFF = 6'h20
	} frc_state_t;

	typedef struct packed {
		frc_state_t                 st;
		logic [`FRC_CTRL_W-1:0]     ctrl;
		logic [31:0]                port_mask;
		logic [15:0]                reset_time;
		logic [15:0]                hold_time;
		logic [15:0]                on_period;
		logic [15:0]                off_period;
		logic [15:0]                secs;
		logic                       ring_latch;
		logic                       relay;
		logic [`FRC_NCAUSE-1:0]     cause;
		logic [`FRC_NIRQ-1:0]       irq_stat;
		logic [`FRC_NIRQ-1:0]       irq_mask;
		logic [31:0]                prdata;
		logic                       pslverr;
	} frc_regs_t;

	typedef struct packed {
		logic [25:0] cnt;
		logic        tick;
	} frc_tick_t;

endpackage

// ### core/frc_tick_if.sv
// Carrier between the relay controller and its seconds prescaler.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ns
`default_nettype none

interface frc_tick_if;
	logic restart;
	logic tick;

	modport ctrl (output restart, input tick);
	modport gen  (input restart, output tick);
endinterface

`default_nettype wire

// ### core/frc_tick.sv
// One-second tick prescaler for the fault relay timers.
// Assumes a free-running system clock; restart realigns the second.
`timescale 1ns/1ns
`default_nettype none
`include "frc_defs.svh"

module frc_tick #(
	parameter int unsigned TICK_CYCLES = `FRC_TICK_CYCLES
) (
	// Clock and reset
	input  wire logic clock_i,
	input  wire logic srst_i,
	// Tick carrier
	frc_tick_if.gen   tk
);
	import frc_pkg::*;

	frc_tick_t r_reg;
	frc_tick_t r_next;

	always_comb begin
		r_next      = r_reg;
		r_next.tick = 1'b0;
		// Realign so a freshly entered period lasts whole seconds
		if (tk.restart) begin
			r_next.cnt = 26'h0000000;
		end else if (r_reg.cnt >= 26'(TICK_CYCLES - 1)) begin
			r_next.cnt  = 26'h0000000;
			r_next.tick = 1'b1;
		end else begin
			r_next.cnt = r_reg.cnt + 26'h0000001;
		end
	end

	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end

	assign tk.tick = r_reg.tick;
endmodule

`default_nettype wire

// ### core/frc_top.sv
// Fault relay controller: binds fault sources to one alarm relay, with
// ping reset and dry output modes, APB registers and one interrupt.
// Assumes all status inputs are synchronous to clock_i.
//
// Design decisions made here: the APB register port and the address map.
`timescale 1ns/1ns
`default_nettype none
`include "frc_defs.svh"

// Function
// - Relay contact open normally, closed while an enabled fault is present.
// - Several sources may be enabled together; any one closes the relay.
// - Power source watches supply one, supply two, or either supply.
// - Each port selected for monitoring closes the relay on link down.
// - Enabled ring source closes the relay on a topology change notice.
// - Enabled ping source closes the relay when the target stops answering.
// - Ping reset mode keeps the contact closed while the remote answers.
// - On ping failure, open the contact for reset time seconds, then close.
// - After re-closing, wait the hold time before pinging again.
// - Dry output alternates closed for on period, open for off period.
// - Periods are whole seconds, zero to 65535, on a 16-bit counter.
// - Digital input source fires on low or high input level as chosen.
// - Report relay state and which event types are causing it.
module frc_top #(
	parameter int unsigned NPORTS      = 10,
	parameter int unsigned TICK_CYCLES = `FRC_TICK_CYCLES
) (
	// Clock and reset
	input  wire logic              clock_i,
	input  wire logic              srst_i,
	// APB slave
	input  wire logic              psel_i,
	input  wire logic              penable_i,
	input  wire logic              pwrite_i,
	input  wire logic [11:0]       paddr_i,
	input  wire logic [31:0]       pwdata_i,
	output logic                   pready_o,
	output logic [31:0]            prdata_o,
	output logic                   pslverr_o,
	// Fault sources
	input  wire logic              supply_one_fail_i,
	input  wire logic              supply_two_fail_i,
	input  wire logic [NPORTS-1:0] link_up_i,
	input  wire logic              ring_change_i,
	input  wire logic              ping_fail_i,
	input  wire logic              digital_input_i,
	// Outputs
	output logic                   ping_enable_o,
	output logic                   relay_close_o,
	output logic                   irq_o
);
	import frc_pkg::*;

	frc_regs_t r_reg;
	frc_regs_t r_next;

	frc_tick_if tk ();

	frc_tick #(
		.TICK_CYCLES (TICK_CYCLES)
	) u_tick (
		.clock_i (clock_i),
		.srst_i  (srst_i),
		.tk      (tk)
	);

	// Per-port link fault
	logic [NPORTS-1:0] link_hit;

	genvar gi;
	generate
		for (gi = 0; gi < NPORTS; gi++) begin : g_link
			assign link_hit[gi] = r_reg.port_mask[gi] & ~link_up_i[gi];
		end
	endgenerate

	// Decoded control fields
	logic       power_en;
	logic [1:0] power_sel;
	logic       link_en;
	logic       ring_en;
	logic       ping_en;
	logic       prst_en;
	logic       dry_en;
	logic       di_en;
	logic       di_high;

	assign power_en  = r_reg.ctrl[`FRC_CTRL_POWER_EN];
	assign power_sel = r_reg.ctrl[`FRC_CTRL_PSEL_HI:`FRC_CTRL_PSEL_LO];
	assign link_en   = r_reg.ctrl[`FRC_CTRL_LINK_EN];
	assign ring_en   = r_reg.ctrl[`FRC_CTRL_RING_EN];
	assign ping_en   = r_reg.ctrl[`FRC_CTRL_PING_EN];
	assign prst_en   = r_reg.ctrl[`FRC_CTRL_PRST_EN];
	assign dry_en    = r_reg.ctrl[`FRC_CTRL_DRY_EN];
	assign di_en     = r_reg.ctrl[`FRC_CTRL_DI_EN];
	assign di_high   = r_reg.ctrl[`FRC_CTRL_DI_HIGH];

	// Timed mode phases, shared by cause bits, status and the ping gate
	logic in_run;
	logic in_prst;
	logic in_dry_on;

	assign in_run    = r_reg.st == FRC_ST_RUN;
	assign in_prst   = (r_reg.st == FRC_ST_OPEN) | (r_reg.st == FRC_ST_HOLD);
	assign in_dry_on = r_reg.st == FRC_ST_DRY_ON;

	// Bus strobes
	logic wr_acc;
	logic rd_setup;

	assign wr_acc   = psel_i & penable_i & pwrite_i;
	assign rd_setup = psel_i & ~penable_i;

	// Combinational helpers
	logic                   power_hit;
	logic                   di_hit;
	logic [`FRC_NCAUSE-1:0] cause_now;
	logic                   mode_close;
	logic                   restart;
	logic                   secs_done_reset;
	logic                   secs_done_hold;
	logic                   secs_done_on;
	logic                   secs_done_off;
	logic [`FRC_NIRQ-1:0]   irq_events;
	logic [`FRC_NIRQ-1:0]   irq_w1c;
	logic                   ring_clr;
	logic [31:0]            rd_word;
	logic                   rd_bad;

	always_comb begin
		case (power_sel)
			`FRC_PSEL_ONE: power_hit = supply_one_fail_i;
			`FRC_PSEL_TWO: power_hit = supply_two_fail_i;
			`FRC_PSEL_ANY: power_hit = supply_one_fail_i | supply_two_fail_i;
			default:       power_hit = 1'b0;
		endcase
	end

	// Low setting fires while the input is off, high while it is on
	assign di_hit = di_high ? digital_input_i : ~digital_input_i;

	assign secs_done_reset = r_reg.secs >= r_reg.reset_time;
	assign secs_done_hold  = r_reg.secs >= r_reg.hold_time;
	assign secs_done_on    = r_reg.secs >= r_reg.on_period;
	assign secs_done_off   = r_reg.secs >= r_reg.off_period;

	// Relay closing contribution of the timed modes
	always_comb begin
		case (r_reg.st)
			FRC_ST_RUN:     mode_close = 1'b1;
			FRC_ST_HOLD:    mode_close = 1'b1;
			FRC_ST_DRY_ON:  mode_close = 1'b1;
			FRC_ST_OPEN:    mode_close = 1'b0;
			FRC_ST_DRY_OFF: mode_close = 1'b0;
			default:        mode_close = 1'b0;
		endcase
	end

	always_comb begin
		cause_now                = '0;
		cause_now[`FRC_C_POWER]  = power_en & power_hit;
		cause_now[`FRC_C_LINK]   = link_en & (|link_hit);
		cause_now[`FRC_C_RING]   = r_reg.ring_latch;
		cause_now[`FRC_C_PING]   = ping_en & ping_fail_i;
		cause_now[`FRC_C_PRST]   = in_prst;
		cause_now[`FRC_C_DRY]    = in_dry_on;
		cause_now[`FRC_C_DI]     = di_en & di_hit;
	end

	// Only faults feed the contact; timed-mode cause bits just report,
	// fed in they would keep the contact shut through the open phase
	logic fault_close;

	assign fault_close = cause_now[`FRC_C_POWER] | cause_now[`FRC_C_LINK]
		| cause_now[`FRC_C_RING] | cause_now[`FRC_C_PING] | cause_now[`FRC_C_DI];

	// Relay, causes, state and seconds in one read-only word
	logic [31:0] status_word;

	assign status_word = {r_reg.secs, 2'h0, r_reg.st, r_reg.cause, r_reg.relay};

	// Register read mux
	always_comb begin
		rd_word = 32'h00000000;
		rd_bad  = 1'b0;
		case (paddr_i)
			`FRC_OFF_CTRL:     rd_word[`FRC_CTRL_W-1:0] = r_reg.ctrl;
			`FRC_OFF_PORTS:    rd_word = r_reg.port_mask;
			`FRC_OFF_RESET_T:  rd_word[15:0] = r_reg.reset_time;
			`FRC_OFF_HOLD_T:   rd_word[15:0] = r_reg.hold_time;
			`FRC_OFF_ON_T:     rd_word[15:0] = r_reg.on_period;
			`FRC_OFF_OFF_T:    rd_word[15:0] = r_reg.off_period;
			`FRC_OFF_STATUS:   rd_word = status_word;
			`FRC_OFF_IRQ_STAT: rd_word[`FRC_NIRQ-1:0] = r_reg.irq_stat;
			`FRC_OFF_IRQ_MASK: rd_word[`FRC_NIRQ-1:0] = r_reg.irq_mask;
			`FRC_OFF_CLEAR:    rd_word = 32'h00000000;
			default:           rd_bad = 1'b1;
		endcase
	end

	always_comb begin
		r_next     = r_reg;
		restart    = 1'b0;
		irq_w1c    = '0;
		ring_clr   = 1'b0;
		irq_events = '0;

		// Register writes, taken in the access phase
		if (wr_acc) begin
			case (paddr_i)
				`FRC_OFF_CTRL:     r_next.ctrl = pwdata_i[`FRC_CTRL_W-1:0];
				`FRC_OFF_PORTS:    r_next.port_mask = pwdata_i & 32'((64'h1 << NPORTS) - 64'h1);
				`FRC_OFF_RESET_T:  r_next.reset_time = pwdata_i[15:0];
				`FRC_OFF_HOLD_T:   r_next.hold_time = pwdata_i[15:0];
				`FRC_OFF_ON_T:     r_next.on_period = pwdata_i[15:0];
				`FRC_OFF_OFF_T:    r_next.off_period = pwdata_i[15:0];
				`FRC_OFF_IRQ_STAT: irq_w1c = pwdata_i[`FRC_NIRQ-1:0];
				`FRC_OFF_IRQ_MASK: r_next.irq_mask = pwdata_i[`FRC_NIRQ-1:0];
				`FRC_OFF_CLEAR:    ring_clr = pwdata_i[0];
				default:           ;
			endcase
		end

		// Read data and error are caught in the setup phase
		if (rd_setup) begin
			r_next.prdata  = pwrite_i ? 32'h00000000 : rd_word;
			r_next.pslverr = rd_bad;
		end

		// A topology change stays latched until software clears it
		if (!ring_en || ring_clr) begin
			r_next.ring_latch = 1'b0;
		end
		if (ring_en && ring_change_i) begin
			r_next.ring_latch = 1'b1;
		end

		// Seconds counter, saturating so a stalled state cannot wrap
		if (tk.tick && r_reg.secs != `FRC_SECS_MAX) begin
			r_next.secs = r_reg.secs + 16'h0001;
		end

		// Timed mode sequencer; ping reset wins over dry output
		case (r_reg.st)
			FRC_ST_IDLE: begin
				if (prst_en) begin
					r_next.st = FRC_ST_RUN;
				end else if (dry_en) begin
					r_next.st = FRC_ST_DRY_ON;
					restart   = 1'b1;
				end
			end
			FRC_ST_RUN: begin
				if (!prst_en) begin
					r_next.st = FRC_ST_IDLE;
				end else if (ping_fail_i) begin
					r_next.st = FRC_ST_OPEN;
					restart   = 1'b1;
				end
			end
			FRC_ST_OPEN: begin
				if (!prst_en) begin
					r_next.st = FRC_ST_IDLE;
				end else if (secs_done_reset) begin
					r_next.st = FRC_ST_HOLD;
					restart   = 1'b1;
				end
			end
			FRC_ST_HOLD: begin
				if (!prst_en) begin
					r_next.st = FRC_ST_IDLE;
				end else if (secs_done_hold) begin
					r_next.st = FRC_ST_RUN;
				end
			end
			FRC_ST_DRY_ON: begin
				if (!dry_en || prst_en) begin
					r_next.st = FRC_ST_IDLE;
				end else if (secs_done_on) begin
					r_next.st = FRC_ST_DRY_OFF;
					restart   = 1'b1;
				end
			end
			FRC_ST_DRY_OFF: begin
				if (!dry_en || prst_en) begin
					r_next.st = FRC_ST_IDLE;
				end else if (secs_done_off) begin
					r_next.st = FRC_ST_DRY_ON;
					restart   = 1'b1;
				end
			end
			default: begin
				r_next.st = FRC_ST_IDLE;
			end
		endcase

		// Restart wins over the tick so the new period starts from zero
		if (restart) begin
			r_next.secs = 16'h0000;
		end

		// Faults OR the mode contact; either one closes the relay
		r_next.relay = fault_close | mode_close;
		r_next.cause = cause_now;

		// Interrupt events: a cause starting, or the relay changing
		irq_events[`FRC_NCAUSE-1:0] = cause_now & ~r_reg.cause;
		irq_events[`FRC_IRQ_RELAY]  = r_next.relay ^ r_reg.relay;
		// Set wins over a clear in the same cycle
		r_next.irq_stat = (r_reg.irq_stat & ~irq_w1c) | irq_events;
	end

	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			r_reg            <= '0;
			r_reg.st         <= FRC_ST_IDLE;
			r_reg.ctrl       <= `FRC_CTRL_RST;
			r_reg.reset_time <= `FRC_TIME_RST;
			r_reg.hold_time  <= `FRC_TIME_RST;
			r_reg.on_period  <= `FRC_TIME_RST;
			r_reg.off_period <= `FRC_TIME_RST;
			r_reg.relay      <= 1'b0;
		end else begin
			r_reg <= r_next;
		end
	end

	assign tk.restart = restart;

	// Ping only once the contact feeds the remote again; pinging it
	// unpowered would read as a fresh failure and restart the cycle
	logic ping_gate;

	assign ping_gate = prst_en & in_run & r_reg.relay;

	// Zero-wait slave: every access completes in its first access cycle
	assign pready_o      = 1'b1;
	assign prdata_o      = r_reg.prdata;
	assign pslverr_o     = r_reg.pslverr & psel_i & penable_i;
	assign relay_close_o = r_reg.relay;
	assign ping_enable_o = ping_en | ping_gate;
	assign irq_o         = |(r_reg.irq_stat & r_reg.irq_mask);
endmodule

`default_nettype wire

// ### bench/frc_remote_model.sv
// Remote powered device fed through the relay contact; answers pings.
// Assumes the bench pulses crash_i to hang it and sets wired_i when powered.
`timescale 1ns/1ns
`default_nettype none

module frc_remote_model (
	// Clock, reset and commands
	input  wire logic clock_i,
	input  wire logic srst_i,
	input  wire logic wired_i,
	input  wire logic crash_i,
	// Contact side
	input  wire logic relay_close_i,
	input  wire logic ping_enable_i,
	output logic      ping_fail_o
);
	logic crashed;

	// Only reset or a power cycle through the contact cures a hang
	always_ff @(posedge clock_i) begin
		if (srst_i || (wired_i && !relay_close_i)) begin
			crashed <= 1'b0;
		end else if (crash_i) begin
			crashed <= 1'b1;
		end
	end
	// An unpowered device cannot answer either
	assign ping_fail_o = crashed || (wired_i && ping_enable_i && !relay_close_i);
endmodule

`default_nettype wire

// ### bench/frc_asserts.sv
// Checker for the fault relay, watching only the top module ports.
// Assumes CTRL and port mask are shadowed exactly from APB writes.
`timescale 1ns/1ns
`default_nettype none

module frc_asserts #(
	parameter int unsigned NPORTS = 10
) (
	// Clock, reset and APB
	input  wire logic              clock_i,
	input  wire logic              srst_i,
	input  wire logic              psel_i,
	input  wire logic              penable_i,
	input  wire logic              pwrite_i,
	input  wire logic [11:0]       paddr_i,
	input  wire logic [31:0]       pwdata_i,
	input  wire logic              pready_o,
	input  wire logic              pslverr_o,
	// Sources and outputs
	input  wire logic              supply_one_fail_i,
	input  wire logic              supply_two_fail_i,
	input  wire logic [NPORTS-1:0] link_up_i,
	input  wire logic              ring_change_i,
	input  wire logic              ping_fail_i,
	input  wire logic              digital_input_i,
	input  wire logic              ping_enable_o,
	input  wire logic              relay_close_o,
	input  wire logic              irq_o
);
	logic [9:0]        c;
	logic [NPORTS-1:0] pm;
	wire               wr = psel_i && penable_i && pwrite_i && pready_o;

	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			c  <= '0;
			pm <= '0;
		end else if (wr && paddr_i == 12'h000) begin
			c <= pwdata_i[9:0];
		end else if (wr && paddr_i == 12'h004) begin
			pm <= pwdata_i[NPORTS-1:0];
		end
	end

	default clocking @(posedge clock_i); endclocking
	default disable iff (srst_i);

	sequence bad_acc;
		psel_i && penable_i && paddr_i > 12'h024;
	endsequence
	sequence closed_next;
		##1 relay_close_o;
	endsequence

	rst_open_a: assert property ($fell(srst_i) |-> !relay_close_o && !irq_o && !ping_enable_o)
		else $error("outputs active after reset");
	power_a: assert property (c[0] && (c[1] && supply_one_fail_i
		|| c[2] && supply_two_fail_i) |-> closed_next)
		else $error("power fault left relay open");
	link_a: assert property (c[3] && |(pm & ~link_up_i) |-> closed_next)
		else $error("link down left relay open");
	ring_a: assert property (c[4] && ring_change_i && !psel_i |-> ##2 relay_close_o [*2])
		else $error("ring change not held on relay");
	ping_a: assert property (c[5] && ping_fail_i |-> closed_next)
		else $error("ping failure left relay open");
	di_a: assert property (c[8] && digital_input_i == c[9] |-> closed_next)
		else $error("digital input level left relay open");
	quiet_open_a: assert property (c == 10'h000 |-> ##2 !relay_close_o)
		else $error("relay closed with no source enabled");
	unmapped_err_a: assert property (bad_acc |-> pslverr_o)
		else $error("unmapped access without error");
endmodule

bind frc_top frc_asserts #(.NPORTS(NPORTS)) chk_u (.clock_i, .srst_i, .psel_i, .penable_i,
	.pwrite_i, .paddr_i, .pwdata_i, .pready_o, .pslverr_o, .supply_one_fail_i,
	.supply_two_fail_i, .link_up_i, .ring_change_i, .ping_fail_i, .digital_input_i,
	.ping_enable_o, .relay_close_o, .irq_o);

`default_nettype wire

// ### bench/frc_top_test.sv
// Self-checking bench for the fault relay controller, driven over APB.
// Assumes the seconds prescaler is shortened to TK clocks.
`timescale 1ns/1ns
`default_nettype none

`define CHK(n, e, a) begin tests_run++; if ((a) !== (e)) begin error_cnt++; \
	$display("wrong value %s exp %0h got %0h", n, e, a); end end

module frc_top_test;
	localparam int TK = 10;
	logic        clock_i = 0, srst_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0;
	logic [11:0] paddr_i = 0;
	logic [31:0] pwdata_i = 0, prdata_o, rd;
	logic [9:0]  link_up_i = 10'h3FF;
	logic        supply_one_fail_i = 0, supply_two_fail_i = 0, ring_change_i = 0;
	logic        digital_input_i = 0, ping_fail_i, wired = 0, crash = 0, er;
	logic        pready_o, pslverr_o, ping_enable_o, relay_close_o, irq_o;
	int          n, cyc = 0, error_cnt = 0, tests_run = 0;

	frc_top #(.TICK_CYCLES(TK)) dut_u (.clock_i, .srst_i, .psel_i, .penable_i, .pwrite_i,
		.paddr_i, .pwdata_i, .pready_o, .prdata_o, .pslverr_o, .supply_one_fail_i,
		.supply_two_fail_i, .link_up_i, .ring_change_i, .ping_fail_i, .digital_input_i,
		.ping_enable_o, .relay_close_o, .irq_o);
	frc_remote_model far_u (.clock_i, .srst_i, .wired_i(wired), .crash_i(crash),
		.relay_close_i(relay_close_o), .ping_enable_i(ping_enable_o), .ping_fail_o(ping_fail_i));

	initial forever #10 clock_i = ~clock_i;

	task automatic summarize();
		$display("checks %0d errors %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	always @(posedge clock_i) begin
		cyc++;
		if (cyc > 20000) begin
			error_cnt++;
			summarize();
		end
	end

	task automatic tk(input int k);
		repeat (k) @(posedge clock_i);
	endtask

	// Outputs read right at the sampling edge, before its updates land
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clock_i);
		psel_i <= 1'b1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge clock_i);
		penable_i <= 1'b1;
		do @(posedge clock_i); while (pready_o !== 1'b1);
		rd = prdata_o;
		er = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask

	task automatic rc(input logic [11:0] a, input logic [31:0] m, e, input string s);
		apb(1'b0, a, 32'h0);
		`CHK(s, e, rd & m)
	endtask

	task automatic meas(ref logic s, input logic v);
		n = 0;
		while (s === v && n < 9999) begin
			@(posedge clock_i);
			n++;
		end
	endtask

	initial begin
		tk(4);
		srst_i <= 1'b0;
		rc(12'h000, 32'hFFFFFFFF, 32'h0, "ctrl");
		rc(12'h018, 32'h3FFF, 32'h100, "status");
		rc(12'h028, 32'hFFFFFFFF, 32'h0, "unmapped");
		`CHK("slverr", 1'b1, er)
		for (int s = 1; s < 4; s++) begin
			apb(1'b1, 12'h000, 32'(1 + 2 * s));
			for (int f = 0; f < 4; f++) begin
				{supply_two_fail_i, supply_one_fail_i} <= 2'(f);
				tk(3);
				`CHK("power", (s & f) != 0, relay_close_o)
			end
		end
		rc(12'h018, 32'hFF, 32'h03, "cause");
		{supply_two_fail_i, supply_one_fail_i} <= 2'b00;
		apb(1'b1, 12'h01C, 32'hFF);
		apb(1'b1, 12'h020, 32'h01);
		supply_two_fail_i <= 1'b1;
		tk(3);
		`CHK("irq", 1'b1, irq_o)
		rc(12'h01C, 32'h81, 32'h81, "irq stat");
		apb(1'b1, 12'h020, 32'h0);
		tk(1);
		`CHK("irq masked", 1'b0, irq_o)
		apb(1'b1, 12'h01C, 32'hFF);
		rc(12'h01C, 32'hFF, 32'h0, "irq clear");
		supply_two_fail_i <= 1'b0;
		apb(1'b1, 12'h004, 32'h204);
		apb(1'b1, 12'h000, 32'h8);
		link_up_i <= 10'h3FD;
		tk(3);
		`CHK("link unwatched", 1'b0, relay_close_o)
		link_up_i <= 10'h1FF;
		tk(3);
		`CHK("link watched", 1'b1, relay_close_o)
		link_up_i <= 10'h3FF;
		apb(1'b1, 12'h000, 32'h10);
		ring_change_i <= 1'b1;
		tk(1);
		ring_change_i <= 1'b0;
		tk(4);
		`CHK("ring", 1'b1, relay_close_o)
		apb(1'b1, 12'h024, 32'h1);
		tk(2);
		`CHK("ring clear", 1'b0, relay_close_o)
		for (int h = 0; h < 2; h++) begin
			apb(1'b1, 12'h000, 32'h107 | (h << 9));
			for (int v = 0; v < 2; v++) begin
				digital_input_i <= 1'(v);
				tk(3);
				`CHK("din", v == h, relay_close_o)
			end
		end
		apb(1'b1, 12'h000, 32'h20);
		crash <= 1'b1;
		tk(1);
		crash <= 1'b0;
		tk(3);
		`CHK("ping", 1'b1, relay_close_o)
		wired <= 1'b1;
		apb(1'b1, 12'h000, 32'h0);
		apb(1'b1, 12'h008, 32'h2);
		apb(1'b1, 12'h00C, 32'h3);
		apb(1'b1, 12'h000, 32'h40);
		meas(ping_enable_o, 1'b0);
		tk(3 * TK);
		`CHK("run closed", 1'b1, relay_close_o)
		crash <= 1'b1;
		tk(1);
		crash <= 1'b0;
		meas(relay_close_o, 1'b1);
		meas(relay_close_o, 1'b0);
		`CHK("open time", 1'b1, n >= 2 * TK && n <= 2 * TK + 3)
		meas(ping_enable_o, 1'b0);
		`CHK("hold time", 1'b1, n >= 3 * TK && n <= 3 * TK + 4)
		apb(1'b1, 12'h000, 32'h0);
		apb(1'b1, 12'h010, 32'hFFFF);
		rc(12'h010, 32'hFFFFFFFF, 32'hFFFF, "on max");
		apb(1'b1, 12'h010, 32'h2);
		apb(1'b1, 12'h014, 32'h1);
		apb(1'b1, 12'h000, 32'h80);
		meas(relay_close_o, 1'b0);
		meas(relay_close_o, 1'b1);
		meas(relay_close_o, 1'b0);
		`CHK("off time", 1'b1, n >= TK && n <= TK + 3)
		meas(relay_close_o, 1'b1);
		`CHK("on time", 1'b1, n >= 2 * TK && n <= 2 * TK + 3)
		summarize();
	end
endmodule

`default_nettype wire
